// ===== inc/brw_pkg.sv
package brw_pkg;

	// Boot strap decode results.
	localparam logic [1:0] SEQ_SEL_0 = 2'h0;
	localparam logic [1:0] SEQ_SEL_1 = 2'h1;
	localparam logic [1:0] SEQ_SEL_2 = 2'h2;

	// Register class reset values.
	localparam logic [6:0] VOLTAGE_SELECT_FIELD_RST = 7'h00;
	localparam logic [7:0] POR_FLAGS_RST = 8'h00;
	localparam logic [7:0] HW_REG_RST = 8'h00;
	localparam logic [7:0] SWO_CTRL_RST = 8'h00;

	// Watchdog tick taken from the 32 kHz domain, expressed in system clocks.
	localparam int WDT_TICK_NS = 31250;
	localparam int SYS_CLK_NS = 40;
	localparam int WDT_TICK_CYC = WDT_TICK_NS / SYS_CLK_NS;
	localparam logic [7:0] WDT_N_RST = 8'h00;

	// Device power states.
	typedef enum logic [2:0] {
		BRW_NOSUPPLY = 3'b000,
		BRW_BACKUP = 3'b001,
		BRW_OFF = 3'b010,
		BRW_ACTIVE = 3'b011,
		BRW_SLEEP = 3'b100
	} brw_pstate_t;

	// Sequence being run.
	typedef enum logic [1:0] {
		BRW_SEQ_NONE = 2'b00,
		BRW_SEQ_OFF_TO_ACTIVE_SEQUENCE = 2'b01,
		BRW_SEQ_ACTIVE_TO_OFF_SEQUENCE = 2'b10,
		BRW_SEQ_SLEEP_TO_OFF_SEQUENCE = 2'b11
	} brw_seq_t;

	function automatic logic [1:0] brw_seq_sel(input logic cfg_strap, input logic sel_strap);
		brw_seq_sel = cfg_strap ? SEQ_SEL_2 : (sel_strap ? SEQ_SEL_1 : SEQ_SEL_0);
	endfunction : brw_seq_sel

endpackage : brw_pkg

// ===== verilog/brw_ctrl.sv
// Contract
// - Boot straps decode to config set and sequence selector 0, 1 or 2.
// - Voltage and forced-voltage fields load from one shared stored value.
// - Strap levels act as branch conditions while a sequence runs.
// - Statically initialised registers are writable by sequence and host.
// - Sequence-written settings become host-writable once the sequence finishes.
// - Power-on reset on no-supply to backup clears all register classes.
// - OFF request with hardware reset runs active- or sleep-to-off sequence.
// - Hardware reset clears hardware and switch-off classes, keeps power-on class.
// - OFF request without hardware reset clears only switch-off class.
// - Thermal, short, good-mask and switch-off cause flags are power-on class.
// - Voltage, mode, clock, enables, watchdog, monitor are switch-off class.
// - Warm reset runs off-to-active from ACTIVE or SLEEP, ends ACTIVE.
// - Warm reset keeps resources outside the sequence, activates those inside.
// - Per resource select bit chooses reload or keep of voltage on warm reset.
// - Reset-in gates power-on requests and triggers cold reset or shutdown.
// - Periodic mode raises interrupt when counter equals 1.
// - Periodic mode shuts down at N if that interrupt stays uncleared.
// - Clearing does not reset counter; it rolls to 0 after N.
// - Counter held at 0 while reset-out low, counts once released.
// - Interrupt mode: any interrupt source restarts the counter.
// - Interrupt mode: host clears sources before N or device shuts down.
// - Watchdog disabled out of reset until enabled.
`timescale 1ns/100ps
module brw_ctrl import brw_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic i_supply_ok,
	input wire logic i_config_set_strap,
	input wire logic i_sequence_select_strap,
	input wire logic [6:0] i_voltage_select_field_set0,
	input wire logic [6:0] i_voltage_select_field_set1,
	input wire logic i_off_req,
	input wire logic i_off_req_hw_reset,
	input wire logic i_on_req,
	input wire logic i_sleep_req,
	input wire logic i_wake_req,
	input wire logic i_warm_reset_pin_n,
	input wire logic i_reset_in,
	input wire logic i_reset_in_cold,
	input wire logic i_seq_done,
	input wire logic i_seq_wr,
	input wire logic i_host_wr,
	input wire logic i_wr_forced,
	input wire logic [6:0] i_wr_voltage,
	input wire logic i_warm_reload_sel,
	input wire logic i_wdt_wr,
	input wire logic i_wdt_enable,
	input wire logic i_wdt_periodic,
	input wire logic [7:0] i_wdt_period,
	input wire logic i_wdt_irq_clear,
	input wire logic i_irq_sources,
	input wire logic [7:0] i_por_flags_set,
	input wire logic i_por_flags_clear,
	output logic [1:0] o_seq_selector,
	output logic o_config_set,
	output logic o_branch_cfg,
	output logic o_branch_sel,
	output logic [2:0] o_power_state,
	output logic [1:0] o_seq_running,
	output logic [6:0] o_switcher_voltage_reg,
	output logic [6:0] o_switcher_forced_voltage_reg,
	output logic o_reset_out,
	output logic o_wdt_irq,
	output logic o_wdt_shutdown,
	output logic [7:0] o_por_flags,
	output logic o_host_wr_ok,
	output logic o_clear_hw_class,
	output logic o_clear_swo_class
);

	// ****************************************
	// State
	// ****************************************
	// All state lives in one packed struct that is registered in one place.
	typedef struct packed {
		brw_pstate_t pst;
		brw_seq_t seq;
		logic seq_hw;
		logic cfg;
		logic [1:0] sel;
		logic [6:0] volt;
		logic [6:0] fvolt;
		logic rst_out;
		logic wen;
		logic wper;
		logic [7:0] wn;
		logic [7:0] wcnt;
		logic [15:0] tick;
		logic wirq;
		logic irq_run;
		logic wshut;
		logic [7:0] por_flags;
		logic clr_hw;
		logic clr_swo;
	} brw_state_t;

	brw_state_t st;
	brw_state_t next_st;

	// ****************************************
	// Helpers
	// ****************************************
	// Both voltage fields reload from the one stored value of the selected set, except on warm reset, which reloads only the voltage field.
	function automatic logic [6:0] stored_volt(input logic cfg,
		input logic [6:0] s0, input logic [6:0] s1);
		stored_volt = cfg ? s1 : s0;
	endfunction : stored_volt

	// ****************************************
	// Watchdog tick and off events
	// ****************************************
	// The tick divider only runs with the watchdog, so counting starts on a whole tick; interrupt-mode restarts do not realign it.
	logic tick_hit;
	logic off_evt;
	logic wdt_run;
	assign tick_hit = (st.tick == 16'(WDT_TICK_CYC - 1));
	// Counter and divider stay cleared while reset-out is low or the watchdog is off.
	assign wdt_run = st.wen && st.rst_out;
	// Reset-in forces a switch-off event, gating any on request.
	assign off_evt = i_off_req || i_reset_in || st.wshut;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_st = st;
		// Class clear outputs are single-cycle pulses.
		next_st.clr_hw = 1'b0;
		next_st.clr_swo = 1'b0;
		// A flag set in the same cycle as a clear wins.
		next_st.por_flags = (st.por_flags & ~{8{i_por_flags_clear}}) | i_por_flags_set;
		unique case (st.pst)
			BRW_NOSUPPLY: begin
				if (i_supply_ok) begin
					next_st.pst = BRW_BACKUP;
					next_st.cfg = i_config_set_strap;
					next_st.sel = brw_seq_sel(i_config_set_strap, i_sequence_select_strap);
					next_st.volt = stored_volt(i_config_set_strap, i_voltage_select_field_set0,
						i_voltage_select_field_set1);
					next_st.fvolt = next_st.volt;
				end
			end
			BRW_BACKUP: begin
				// Supply thresholds are outside this block, so backup moves on at the next edge.
				next_st.pst = BRW_OFF;
			end
			BRW_OFF: begin
				// Reset-in gates the power-on request.
				if (st.seq == BRW_SEQ_NONE && i_on_req && !i_reset_in) begin
					next_st.seq = BRW_SEQ_OFF_TO_ACTIVE_SEQUENCE;
				end
			end
			BRW_ACTIVE: begin
				if (st.seq == BRW_SEQ_NONE && i_sleep_req) begin
					next_st.pst = BRW_SLEEP;
				end
			end
			BRW_SLEEP: begin
				if (st.seq == BRW_SEQ_NONE && i_wake_req) begin
					next_st.pst = BRW_ACTIVE;
				end
			end
			default: begin
				next_st.pst = BRW_NOSUPPLY;
			end
		endcase
		// An off event outranks a warm reset that arrives in the same cycle.
		if ((st.pst == BRW_ACTIVE || st.pst == BRW_SLEEP) && st.seq == BRW_SEQ_NONE) begin
			if (off_evt) begin
				next_st.seq = (st.pst == BRW_ACTIVE) ? BRW_SEQ_ACTIVE_TO_OFF_SEQUENCE : BRW_SEQ_SLEEP_TO_OFF_SEQUENCE;
				next_st.seq_hw = i_reset_in ? i_reset_in_cold : i_off_req_hw_reset;
				next_st.rst_out = 1'b0;
			end else if (!i_warm_reset_pin_n) begin
				next_st.seq = BRW_SEQ_OFF_TO_ACTIVE_SEQUENCE;
				next_st.rst_out = 1'b0;
				if (i_warm_reload_sel) begin
					next_st.volt = stored_volt(st.cfg, i_voltage_select_field_set0,
						i_voltage_select_field_set1);
				end
			end
		end
		// While a sequence runs only it may write the voltage fields; host writes are dropped.
		if (st.seq != BRW_SEQ_NONE) begin
			if (i_seq_wr) begin
				if (i_wr_forced) next_st.fvolt = i_wr_voltage;
				else next_st.volt = i_wr_voltage;
			end
			if (i_seq_done) begin
				next_st.seq = BRW_SEQ_NONE;
				if (st.seq == BRW_SEQ_OFF_TO_ACTIVE_SEQUENCE) begin
					next_st.pst = BRW_ACTIVE;
					// Reset-out is released only once the power-up sequence has finished.
					next_st.rst_out = 1'b1;
				end else begin
					next_st.pst = BRW_OFF;
					// The switch-off class returns to its load values; power-on flags are kept.
					next_st.clr_swo = 1'b1;
					next_st.clr_hw = st.seq_hw;
					next_st.volt = stored_volt(st.cfg, i_voltage_select_field_set0,
						i_voltage_select_field_set1);
					next_st.fvolt = next_st.volt;
					next_st.wen = 1'b0;
					next_st.wper = 1'b0;
					next_st.wn = WDT_N_RST;
					next_st.wshut = 1'b0;
				end
			end
		end else if (i_host_wr) begin
			if (i_wr_forced) next_st.fvolt = i_wr_voltage;
			else next_st.volt = i_wr_voltage;
		end
		if (i_wdt_wr) begin
			next_st.wen = i_wdt_enable;
			next_st.wper = i_wdt_periodic;
			next_st.wn = i_wdt_period;
		end
		// Watchdog: periodic mode counts whole periods, interrupt mode counts while sources stand.
		next_st.tick = (!wdt_run || tick_hit) ? 16'h0000 : st.tick + 16'h0001;
		if (!wdt_run) begin
			next_st.wcnt = 8'h00;
			next_st.wirq = 1'b0;
			next_st.irq_run = 1'b0;
		end else if (st.wper) begin
			// The interrupt rises as the counter steps from 0 to 1.
			if (i_wdt_irq_clear) next_st.wirq = 1'b0;
			if (tick_hit) begin
				if (st.wcnt >= st.wn) begin
					next_st.wcnt = 8'h00;
					if (st.wirq) next_st.wshut = 1'b1;
				end else begin
					next_st.wcnt = st.wcnt + 8'h01;
					if (st.wcnt == 8'h00) next_st.wirq = 1'b1;
				end
			end
		end else begin
			// A fresh source edge restarts the count; dropping all sources discards it.
			next_st.wirq = i_irq_sources;
			if (i_irq_sources && !st.wirq) begin
				next_st.wcnt = 8'h00;
				next_st.irq_run = 1'b1;
			end else if (!i_irq_sources) begin
				next_st.irq_run = 1'b0;
				next_st.wcnt = 8'h00;
			end else if (tick_hit && st.irq_run) begin
				if (st.wcnt + 8'h01 >= st.wn) next_st.wshut = 1'b1;
				else next_st.wcnt = st.wcnt + 8'h01;
			end
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st.pst <= BRW_NOSUPPLY;
			st.seq <= BRW_SEQ_NONE;
			st.seq_hw <= 1'b0;
			st.cfg <= 1'b0;
			st.sel <= SEQ_SEL_0;
			st.volt <= VOLTAGE_SELECT_FIELD_RST;
			st.fvolt <= VOLTAGE_SELECT_FIELD_RST;
			st.rst_out <= 1'b0;
			st.wen <= 1'b0;
			st.wper <= 1'b0;
			st.wn <= WDT_N_RST;
			st.wcnt <= 8'h00;
			st.tick <= 16'h0000;
			st.wirq <= 1'b0;
			st.irq_run <= 1'b0;
			st.wshut <= 1'b0;
			st.por_flags <= POR_FLAGS_RST;
			// Both class clears stand during power-on reset so every register class starts clean.
			st.clr_hw <= 1'b1;
			st.clr_swo <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign o_seq_selector = st.sel;
	assign o_config_set = st.cfg;
	// Branch conditions read the live strap pins, not the latched copy.
	assign o_branch_cfg = i_config_set_strap;
	assign o_branch_sel = i_sequence_select_strap;
	assign o_power_state = st.pst;
	assign o_seq_running = st.seq;
	assign o_switcher_voltage_reg = st.volt;
	assign o_switcher_forced_voltage_reg = st.fvolt;
	assign o_reset_out = st.rst_out;
	assign o_wdt_irq = st.wirq;
	assign o_wdt_shutdown = st.wshut;
	assign o_por_flags = st.por_flags;
	assign o_host_wr_ok = (st.seq == BRW_SEQ_NONE);
	assign o_clear_hw_class = st.clr_hw;
	assign o_clear_swo_class = st.clr_swo;

endmodule : brw_ctrl

// ===== dv/brw_host_model.sv
`timescale 1ns/100ps
module brw_host_model (
	input wire logic i_sys_clk,
	input wire logic i_wdt_irq,
	input wire logic i_ack_en,
	input wire logic [3:0] i_delay,
	output logic o_irq_clear
);
	logic [3:0] cnt = 4'h0;
	initial o_irq_clear = 1'b0;
	// The host answers a raised interrupt after a chosen delay, or not at all.
	always @(negedge i_sys_clk) begin
		o_irq_clear <= i_wdt_irq && i_ack_en && cnt == i_delay;
		cnt <= i_wdt_irq ? cnt + 4'h1 : 4'h0;
	end
endmodule : brw_host_model

// ===== dv/brw_ctrl_asserts.sv
`timescale 1ns/100ps
module brw_ctrl_asserts import brw_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic i_config_set_strap,
	input wire logic i_sequence_select_strap,
	input wire logic i_off_req,
	input wire logic i_reset_in,
	input wire logic i_warm_reset_pin_n,
	input wire logic i_por_flags_clear,
	input wire logic [1:0] o_seq_selector,
	input wire logic o_branch_cfg,
	input wire logic o_branch_sel,
	input wire logic [2:0] o_power_state,
	input wire logic [1:0] o_seq_running,
	input wire logic [6:0] o_switcher_voltage_reg,
	input wire logic [6:0] o_switcher_forced_voltage_reg,
	input wire logic o_reset_out,
	input wire logic o_wdt_shutdown,
	input wire logic [7:0] o_por_flags,
	input wire logic o_host_wr_ok,
	input wire logic o_wdt_irq,
	input wire logic o_clear_hw_class,
	input wire logic o_clear_swo_class
);
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	logic idle;
	assign idle = o_seq_running == BRW_SEQ_NONE && o_power_state == BRW_ACTIVE;
	strap_decode_a: assert property ($rose(o_power_state == BRW_BACKUP) |-> o_seq_selector ==
		($past(i_config_set_strap) ? SEQ_SEL_2 : {1'b0, $past(i_sequence_select_strap)})) else $error("bad selector");
	voltage_select_field_pair_a: assert property (o_power_state == BRW_BACKUP |->
		o_switcher_voltage_reg == o_switcher_forced_voltage_reg) else $error("voltage fields differ");
	branch_live_a: assert property (o_branch_cfg == i_config_set_strap &&
		o_branch_sel == i_sequence_select_strap) else $error("branch levels wrong");
	host_gate_a: assert property (o_host_wr_ok == (o_seq_running == BRW_SEQ_NONE)) else $error("host gate wrong");
	por_keep_a: assert property (!i_por_flags_clear |=>
		(o_por_flags & $past(o_por_flags)) == $past(o_por_flags)) else $error("flag lost");
	clear_nest_a: assert property (o_clear_hw_class |-> o_clear_swo_class) else $error("class clear order");
	wdt_hold_a: assert property (!o_reset_out && !$past(o_reset_out) |-> !o_wdt_irq)
		else $error("watchdog active while reset-out low");
	off_start_a: assert property (idle && i_off_req |=> o_seq_running == BRW_SEQ_ACTIVE_TO_OFF_SEQUENCE && !o_reset_out)
		else $error("off sequence not started");
	warm_start_a: assert property (idle && !i_warm_reset_pin_n && !i_off_req && !i_reset_in && !o_wdt_shutdown
		|=> o_seq_running == BRW_SEQ_OFF_TO_ACTIVE_SEQUENCE && !o_reset_out) else $error("warm sequence not started");
	on_gate_a: assert property (o_power_state == BRW_OFF && o_seq_running == BRW_SEQ_NONE && i_reset_in
		|=> o_seq_running == BRW_SEQ_NONE) else $error("power-on not gated");
endmodule : brw_ctrl_asserts
bind brw_ctrl brw_ctrl_asserts u_chk (.i_sys_clk, .i_arst_n, .i_config_set_strap, .i_sequence_select_strap,
	.i_off_req, .i_reset_in, .i_warm_reset_pin_n, .i_por_flags_clear, .o_seq_selector, .o_branch_cfg,
	.o_branch_sel, .o_power_state, .o_seq_running, .o_switcher_voltage_reg, .o_switcher_forced_voltage_reg,
	.o_reset_out, .o_wdt_shutdown, .o_por_flags, .o_host_wr_ok, .o_wdt_irq, .o_clear_hw_class, .o_clear_swo_class);

// ===== dv/brw_ctrl_bench.sv
`timescale 1ns/100ps
module brw_ctrl_bench import brw_pkg::*;;
	logic i_sys_clk, i_arst_n, i_supply_ok, i_config_set_strap, i_sequence_select_strap, i_off_req;
	logic i_off_req_hw_reset, i_on_req, i_sleep_req, i_wake_req, i_warm_reset_pin_n, i_reset_in, i_reset_in_cold;
	logic i_seq_done, i_seq_wr, i_host_wr, i_wr_forced, i_warm_reload_sel, i_wdt_wr, i_wdt_enable, i_wdt_periodic;
	logic i_wdt_irq_clear, i_irq_sources, i_por_flags_clear, o_config_set, o_branch_cfg, o_branch_sel, ack_en;
	logic o_reset_out, o_wdt_irq, o_wdt_shutdown, o_host_wr_ok, o_clear_hw_class, o_clear_swo_class;
	logic [6:0] i_voltage_select_field_set0, i_voltage_select_field_set1, i_wr_voltage, vexp, vseq;
	logic [6:0] o_switcher_voltage_reg, o_switcher_forced_voltage_reg;
	logic [7:0] i_wdt_period, i_por_flags_set, o_por_flags, flags;
	logic [1:0] o_seq_selector, o_seq_running, clr_seen;
	logic [2:0] o_power_state, last_st;
	logic [3:0] delay;
	logic [2:0] exp_q[$];
	int bad_count, total_checks, k;
	brw_ctrl uut (.i_sys_clk, .i_arst_n, .i_supply_ok, .i_config_set_strap, .i_sequence_select_strap,
		.i_voltage_select_field_set0, .i_voltage_select_field_set1, .i_off_req, .i_off_req_hw_reset, .i_on_req,
		.i_sleep_req, .i_wake_req, .i_warm_reset_pin_n, .i_reset_in, .i_reset_in_cold, .i_seq_done, .i_seq_wr,
		.i_host_wr, .i_wr_forced, .i_wr_voltage, .i_warm_reload_sel, .i_wdt_wr, .i_wdt_enable, .i_wdt_periodic,
		.i_wdt_period, .i_wdt_irq_clear, .i_irq_sources, .i_por_flags_set, .i_por_flags_clear, .o_seq_selector,
		.o_config_set, .o_branch_cfg, .o_branch_sel, .o_power_state, .o_seq_running, .o_switcher_voltage_reg,
		.o_switcher_forced_voltage_reg, .o_reset_out, .o_wdt_irq, .o_wdt_shutdown, .o_por_flags, .o_host_wr_ok,
		.o_clear_hw_class, .o_clear_swo_class);
	brw_host_model host (.i_sys_clk, .i_wdt_irq(o_wdt_irq), .i_ack_en(ack_en), .i_delay(delay),
		.o_irq_clear(i_wdt_irq_clear));
	// ****************************************
	// Stimulus and scoreboard
	// ****************************************
	initial begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end
	task automatic cmp(input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp
	task automatic test_done();
		if (exp_q.size() != 0) bad_count++;
		if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done
	task automatic cyc(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask : cyc
	task automatic wait_st(input logic [2:0] s);
		for (k = 0; k < 9000 && o_power_state !== s; k++) cyc(1);
		if (k == 9000) begin
			bad_count++;
			test_done();
		end
	endtask : wait_st
	task automatic run_seq(input logic [2:0] s, input logic w);
		for (k = 0; k < 9000 && o_seq_running === BRW_SEQ_NONE; k++) cyc(1);
		if (k == 9000) begin
			bad_count++;
			test_done();
		end
		i_on_req = 1'b0;
		i_off_req = 1'b0;
		i_warm_reset_pin_n = 1'b1;
		if (s !== o_power_state) exp_q.push_back(s);
		if (w) begin
			vseq = 7'($urandom);
			{i_wr_forced, i_wr_voltage, i_seq_wr} = {1'b1, vseq, 1'b1};
			cyc(1);
			{i_seq_wr, i_host_wr, i_wr_voltage} = {2'b01, ~vseq};
			cyc(1);
			{i_host_wr, i_wr_forced} = 2'b00;
			cmp({1'b0, vseq}, {1'b0, o_switcher_forced_voltage_reg});
			cmp(8'h00, {7'h00, o_host_wr_ok});
		end
		cyc(2);
		i_seq_done = 1'b1;
		cyc(1);
		clr_seen = {o_clear_hw_class, o_clear_swo_class};
		i_seq_done = 1'b0;
		wait_st(s);
	endtask : run_seq
	task automatic power_up(input logic c, input logic s);
		i_arst_n = 1'b0;
		i_supply_ok = 1'b0;
		i_config_set_strap = c;
		i_sequence_select_strap = s;
		i_voltage_select_field_set0 = 7'($urandom);
		i_voltage_select_field_set1 = 7'($urandom);
		vexp = c ? i_voltage_select_field_set1 : i_voltage_select_field_set0;
		cyc(16);
		cmp(8'h03, {6'h00, o_clear_hw_class, o_clear_swo_class});
		i_arst_n = 1'b1;
		cyc(1);
		i_supply_ok = 1'b1;
		exp_q.push_back(BRW_BACKUP);
		exp_q.push_back(BRW_OFF);
		wait_st(BRW_OFF);
		cmp(c ? 8'h02 : {7'h00, s}, o_seq_selector);
		cmp(vexp, o_switcher_voltage_reg);
		cmp(vexp, o_switcher_forced_voltage_reg);
		cmp({7'h00, c}, {7'h00, o_config_set});
	endtask : power_up
	always @(posedge i_sys_clk) begin
		#1;
		if (i_arst_n && o_power_state !== last_st) begin
			if (exp_q.size() == 0) cmp(8'h00, 8'hff);
			else cmp(exp_q.pop_front(), o_power_state);
		end
		last_st = o_power_state;
	end
	initial begin
		{i_off_req, i_off_req_hw_reset, i_on_req, i_sleep_req, i_wake_req, i_reset_in, i_seq_done, i_seq_wr} = '0;
		{i_host_wr, i_wr_forced, i_warm_reload_sel, i_wdt_wr, i_wdt_enable, i_wdt_periodic, ack_en} = '0;
		{i_irq_sources, i_por_flags_clear, i_por_flags_set, i_wdt_period, i_wr_voltage, last_st} = '0;
		i_warm_reset_pin_n = 1'b1;
		delay = 4'($urandom(32'hb459));
		i_reset_in_cold = 1'($urandom);
		for (int p = 0; p < 4; p++) power_up(p[1], p[0]);
		i_reset_in = 1'b1;
		i_on_req = 1'b1;
		cyc(4);
		cmp(BRW_OFF, o_power_state);
		i_reset_in = 1'b0;
		run_seq(BRW_ACTIVE, 1'b0);
		cmp(8'h01, o_reset_out);
		i_wr_voltage = 7'($urandom);
		i_host_wr = 1'b1;
		cyc(1);
		i_host_wr = 1'b0;
		cyc(1);
		cmp(i_wr_voltage, o_switcher_voltage_reg);
		i_warm_reset_pin_n = 1'b0;
		i_warm_reload_sel = 1'b1;
		run_seq(BRW_ACTIVE, 1'b0);
		cmp(vexp, o_switcher_voltage_reg);
		i_por_flags_set = 8'($urandom);
		flags = i_por_flags_set;
		i_wdt_wr = 1'b1;
		{i_wdt_enable, i_wdt_periodic, i_wdt_period, ack_en} = {2'b11, 8'h02, 1'b1};
		cyc(1);
		{i_wdt_wr, i_por_flags_set} = '0;
		cyc(WDT_TICK_CYC - 1);
		cmp(8'h00, {7'h00, o_wdt_irq});
		cyc(1);
		cmp(8'h01, {7'h00, o_wdt_irq});
		cyc(WDT_TICK_CYC * 6);
		cmp(8'h00, o_wdt_shutdown);
		ack_en = 1'b0;
		run_seq(BRW_OFF, 1'b0);
		cmp(flags, o_por_flags);
		cmp(8'h01, {6'h00, clr_seen});
		i_on_req = 1'b1;
		run_seq(BRW_ACTIVE, 1'b1);
		{i_wr_forced, i_wr_voltage, i_host_wr} = {1'b1, ~vseq, 1'b1};
		cyc(1);
		{i_wr_forced, i_host_wr} = 2'b00;
		cmp({1'b0, ~vseq}, {1'b0, o_switcher_forced_voltage_reg});
		i_wdt_wr = 1'b1;
		{i_wdt_enable, i_wdt_periodic, i_wdt_period, i_irq_sources} = {2'b10, 8'h02, 1'b1};
		cyc(1);
		i_wdt_wr = 1'b0;
		cyc(WDT_TICK_CYC);
		i_irq_sources = 1'b0;
		cyc(WDT_TICK_CYC * 3);
		cmp(8'h00, o_wdt_shutdown);
		i_irq_sources = 1'b1;
		run_seq(BRW_OFF, 1'b0);
		i_irq_sources = 1'b0;
		cmp(8'h01, {6'h00, clr_seen});
		i_on_req = 1'b1;
		run_seq(BRW_ACTIVE, 1'b0);
		i_off_req = 1'b1;
		i_off_req_hw_reset = 1'b1;
		run_seq(BRW_OFF, 1'b0);
		cmp(flags, o_por_flags);
		cmp(8'h03, {6'h00, clr_seen});
		i_on_req = 1'b1;
		run_seq(BRW_ACTIVE, 1'b0);
		i_reset_in = 1'b1;
		run_seq(BRW_OFF, 1'b0);
		i_reset_in = 1'b0;
		cmp({6'h00, i_reset_in_cold, 1'b1}, {6'h00, clr_seen});
		test_done();
	end
endmodule : brw_ctrl_bench
